// File: inc/sfifo_pkg.sv
// constants and carrier types shared by the serial fifo control files
package sfifo_pkg;
  localparam int WORD_BITS       = 9;
  localparam int DEPTH_SMALL     = 2048;
  localparam int DEPTH_LARGE     = 4096;
  localparam int TAP_LOW_BITS    = 8;
  localparam int TAP_HIGH_BITS   = 9;
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int CHAIN_PULSE_NS  = 50;
  localparam int CHAIN_PULSE_CYC = (CHAIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AXI_AW          = 4;
  localparam logic [AXI_AW-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 4'h4;
  localparam logic [AXI_AW-1:0] ADDR_FILL   = 4'h8;
  localparam logic [AXI_AW-1:0] ADDR_PTRS   = 4'hC;
  localparam int CTRL_DEPTH_BIT  = 0;
  localparam int PTRS_WPTR_LSB   = 16;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // chain token ownership, gray coded along the ring order
  typedef enum logic [2:0] {
    TOK_NONE_W = 3'h0,
    TOK_W      = 3'h1,
    TOK_WR     = 3'h3,
    TOK_R      = 3'h2,
    TOK_NONE_R = 3'h6
  } token_t;

  // asynchronous pins, carried together through the synchroniser
  typedef struct packed {
    logic shift_clk;
    logic serial_bit;
    logic chain_in;
    logic reset_n;
    logic first_load_or_rewind_n_n;
    logic token_in_n;
    logic next_word_n;
    logic read_n;
  } pin_in_t;

  // status register layout
  typedef struct packed {
    token_t tok;
    logic   xo_n;
    logic   first_n;
    logic   almost_n;
    logic   half_full_n;
    logic   full_n;
    logic   empty_n;
  } status_t;
endpackage

// File: src/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output      logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;

  sync_t r;
  sync_t nx;

  // first stage feeds only the second
  always_comb begin
    nx        = r;
    nx.meta   = din;
    nx.stable = r.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{meta: RST_VAL, stable: RST_VAL};
    end else if (ce) begin
      r <= nx;
    end
  end

  assign dout = r.stable;
endmodule

// File: src/serial_fifo_reset_expansion_ctrl.sv
// serial-in parallel-out fifo with reset, rewind, width cascade and depth chain control
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module serial_fifo_reset_expansion_ctrl #(
  parameter int DEPTH  = sfifo_pkg::DEPTH_LARGE,
  parameter int ALMOST = DEPTH / 8
) (
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  input  wire logic                         ce,
  input  wire logic                         serial_shift_clk,
  input  wire logic                         serial_data_in,
  input  wire logic                         serial_chain_in,
  input  wire logic                         reset_n_in,
  input  wire logic                         first_load_or_rewind_n,
  input  wire logic                         chain_token_in_n,
  input  wire logic                         next_word_n,
  input  wire logic                         read_n,
  output      logic                         tap_eight_bits,
  output      logic                         tap_nine_bits,
  output      logic                         chain_token_out_n,
  output      logic                         empty_n,
  output      logic                         full_n,
  output      logic                         half_full_n,
  output      logic                         almost_empty_full_n,
  output      logic [sfifo_pkg::WORD_BITS-1:0] data_out,
  output      logic                         data_out_oe,
  input  wire logic [sfifo_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                         awvalid,
  output      logic                         awready,
  input  wire logic [31:0]                  wdata,
  input  wire logic [3:0]                   wstrb,
  input  wire logic                         wvalid,
  output      logic                         wready,
  output      logic [1:0]                   bresp,
  output      logic                         bvalid,
  input  wire logic                         bready,
  input  wire logic [sfifo_pkg::AXI_AW-1:0] araddr,
  input  wire logic                         arvalid,
  output      logic                         arready,
  output      logic [31:0]                  rdata,
  output      logic [1:0]                   rresp,
  output      logic                         rvalid,
  input  wire logic                         rready
);
  localparam int PW = $clog2(DEPTH);
  localparam int WB = sfifo_pkg::WORD_BITS;
  localparam int AW = sfifo_pkg::AXI_AW;
  localparam int XW = $clog2(sfifo_pkg::CHAIN_PULSE_CYC + 1);
  localparam logic [PW:0]   FILL_FULL = (PW + 1)'(DEPTH);
  localparam logic [PW:0]   FILL_HALF = (PW + 1)'(DEPTH / 2);
  localparam logic [PW:0]   FILL_LOW  = (PW + 1)'(ALMOST);
  localparam logic [PW:0]   FILL_HIGH = (PW + 1)'(DEPTH - ALMOST);
  localparam logic [PW-1:0] PTR_LAST  = PW'(DEPTH - 1);
  localparam logic [XW-1:0] XO_LAST   = XW'(sfifo_pkg::CHAIN_PULSE_CYC - 1);
  localparam sfifo_pkg::pin_in_t PIN_IDLE = '{shift_clk: 1'b0, serial_bit: 1'b0, chain_in: 1'b1,
    reset_n: 1'b1, first_load_or_rewind_n_n: 1'b1, token_in_n: 1'b1, next_word_n: 1'b1, read_n: 1'b1};

  typedef struct packed {
    logic [PW-1:0]     rptr;
    logic [PW-1:0]     wptr;
    logic [PW:0]       fill;
    logic [WB-1:0]     q;
    logic              q_oe;
    logic              empty_n;
    logic              full_n;
    logic              half_full_n;
    logic              almost_n;
    logic              sclk_prev;
    logic              nw_prev;
    logic              rd_prev;
    logic              xi_prev;
    sfifo_pkg::token_t tok;
    logic              xo_n;
    logic [XW-1:0]     xo_cnt;
    logic              depth_mode;
    logic              first_n;
    logic              awready;
    logic              wready;
    logic              aw_full;
    logic              w_full;
    logic [AW-1:0]     awaddr_q;
    logic              wbit_q;
    logic              wlane_q;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } st_t;

  function automatic st_t reset_state();
    st_t s;
    s             = '0;
    s.full_n      = 1'b1;
    s.half_full_n = 1'b1;
    s.nw_prev     = 1'b1;
    s.rd_prev     = 1'b1;
    s.xi_prev     = 1'b1;
    s.xo_n        = 1'b1;
    s.first_n     = 1'b1;
    s.awready     = 1'b1;
    s.wready      = 1'b1;
    s.arready     = 1'b1;
    return s;
  endfunction

  // register decode shared by the write and read channels
  function automatic logic known_addr(input logic [AW-1:0] a);
    return a inside {sfifo_pkg::ADDR_CTRL, sfifo_pkg::ADDR_STATUS, sfifo_pkg::ADDR_FILL, sfifo_pkg::ADDR_PTRS};
  endfunction

  st_t                 r;
  st_t                 nx;
  sfifo_pkg::pin_in_t  pin_raw;
  sfifo_pkg::pin_in_t  pin;
  sfifo_pkg::status_t  status;
  logic [WB-1:0]       word;
  logic [WB-1:0]       mem [DEPTH];
  logic                step;
  logic                nw_rise;
  logic                rd_fall;
  logic                xi_fall;
  logic                may_write;
  logic                may_read;
  logic                wr_en;
  logic                rd_en;
  logic                wr_wrap;
  logic                rd_wrap;
  logic [31:0]         rd_word;

  assign pin_raw = '{shift_clk: serial_shift_clk, serial_bit: serial_data_in, chain_in: serial_chain_in,
    reset_n: reset_n_in, first_load_or_rewind_n_n: first_load_or_rewind_n, token_in_n: chain_token_in_n,
    next_word_n: next_word_n, read_n: read_n};

  pin_sync #(
    .W       ($bits(sfifo_pkg::pin_in_t)),
    .RST_VAL (PIN_IDLE)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .din     (pin_raw),
    .dout    (pin)
  );

  // bits shift only while the chain input is high, so a standalone part tied high shifts on every rising shift clock edge
  assign step    = pin.shift_clk & ~r.sclk_prev & pin.chain_in;
  assign nw_rise = pin.next_word_n & ~r.nw_prev;
  assign rd_fall = ~pin.read_n & r.rd_prev;
  assign xi_fall = ~pin.token_in_n & r.xi_prev;

  serial_word_shift #(
    .WB       (WB)
  ) u_shift (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .step     (step),
    .bit_in   (pin.serial_bit),
    .restart  (nw_rise),
    .word     (word),
    .tap_low  (tap_eight_bits),
    .tap_high (tap_nine_bits)
  );

  // storage, nine bits per word; wider or deeper arrays are built from several parts
  always_ff @(posedge aclk) begin
    if (ce && wr_en) begin
      mem[r.wptr] <= word;
    end
  end

  // status and pointer views for the read channel
  always_comb begin
    status  = '{tok: r.tok, xo_n: r.xo_n, first_n: r.first_n, almost_n: r.almost_n,
                half_full_n: r.half_full_n, full_n: r.full_n, empty_n: r.empty_n};
    rd_word = '0;
    unique case (araddr)
      sfifo_pkg::ADDR_CTRL:   rd_word[sfifo_pkg::CTRL_DEPTH_BIT] = r.depth_mode;
      sfifo_pkg::ADDR_STATUS: rd_word = 32'(status);
      sfifo_pkg::ADDR_FILL:   rd_word = 32'(r.fill);
      sfifo_pkg::ADDR_PTRS:   rd_word = 32'(r.rptr) | (32'(r.wptr) << sfifo_pkg::PTRS_WPTR_LSB);
      default:                rd_word = '0;
    endcase
  end

  // fifo pointers, flags, chain token and register bus
  always_comb begin
    nx           = r;
    nx.sclk_prev = pin.shift_clk;
    nx.nw_prev   = pin.next_word_n;
    nx.rd_prev   = pin.read_n;
    nx.xi_prev   = pin.token_in_n;
    nx.q_oe      = ~pin.read_n;
    may_write    = !r.depth_mode || (r.tok inside {sfifo_pkg::TOK_W, sfifo_pkg::TOK_WR});
    may_read     = !r.depth_mode || (r.tok inside {sfifo_pkg::TOK_WR, sfifo_pkg::TOK_R});
    wr_en        = aresetn && pin.reset_n && nw_rise && r.full_n && may_write;
    rd_en        = aresetn && pin.reset_n && rd_fall && r.empty_n && may_read
                   && (r.depth_mode || pin.first_load_or_rewind_n_n);
    wr_wrap      = wr_en && r.depth_mode && (r.wptr == PTR_LAST);
    rd_wrap      = rd_en && r.depth_mode && (r.rptr == PTR_LAST);

    // pointer advance and fill count
    if (wr_en) begin
      nx.wptr = r.wptr + 1'b1;
    end
    if (rd_en) begin
      nx.rptr = r.rptr + 1'b1;
      nx.q    = mem[r.rptr];
    end
    if (wr_en && !rd_en) begin
      nx.fill = r.fill + 1'b1;
    end else if (rd_en && !wr_en) begin
      nx.fill = r.fill - 1'b1;
    end

    // token ring: write access travels ahead of read access
    if (r.depth_mode) begin
      unique case (r.tok)
        sfifo_pkg::TOK_NONE_W: if (xi_fall) nx.tok = sfifo_pkg::TOK_W;
        sfifo_pkg::TOK_W: begin
          if (wr_wrap) nx.tok = sfifo_pkg::TOK_NONE_R;
          else if (xi_fall) nx.tok = sfifo_pkg::TOK_WR;
        end
        sfifo_pkg::TOK_WR: begin
          if (wr_wrap) nx.tok = sfifo_pkg::TOK_R;
          else if (rd_wrap) nx.tok = sfifo_pkg::TOK_W;
        end
        sfifo_pkg::TOK_R: begin
          if (rd_wrap) nx.tok = sfifo_pkg::TOK_NONE_W;
          else if (xi_fall) nx.tok = sfifo_pkg::TOK_WR;
        end
        sfifo_pkg::TOK_NONE_R: if (xi_fall) nx.tok = sfifo_pkg::TOK_R;
        default: nx.tok = sfifo_pkg::TOK_NONE_W;
      endcase
    end

    // low pulse on the token output hands access to the next part
    if (wr_wrap || rd_wrap) begin
      nx.xo_n   = 1'b0;
      nx.xo_cnt = XO_LAST;
    end else if (!r.xo_n) begin
      if (r.xo_cnt == '0) nx.xo_n = 1'b1;
      else nx.xo_cnt = r.xo_cnt - 1'b1;
    end

    // rewind only outside chain mode
    if (!r.depth_mode && pin.reset_n && !pin.first_load_or_rewind_n_n) begin
      nx.rptr = '0;
      nx.fill = (nx.fill == FILL_FULL) ? FILL_FULL : {1'b0, nx.wptr};
    end

    // device reset; first-load level caught while reset is low
    if (!pin.reset_n) begin
      nx.rptr    = '0;
      nx.wptr    = '0;
      nx.fill    = '0;
      nx.first_n = pin.first_load_or_rewind_n_n;
      nx.tok     = pin.first_load_or_rewind_n_n ? sfifo_pkg::TOK_NONE_W : sfifo_pkg::TOK_WR;
      nx.xo_n    = 1'b1;
      nx.xo_cnt  = '0;
    end

    // write channel: address and data in either order, answer after both
    if (r.bvalid && bready) nx.bvalid = 1'b0;
    if (r.aw_full && r.w_full && !r.bvalid) begin
      nx.bvalid  = 1'b1;
      nx.bresp   = known_addr(r.awaddr_q) ? sfifo_pkg::RESP_OKAY : sfifo_pkg::RESP_SLVERR;
      nx.aw_full = 1'b0;
      nx.w_full  = 1'b0;
      if (r.awaddr_q == sfifo_pkg::ADDR_CTRL && r.wlane_q) nx.depth_mode = r.wbit_q;
    end
    if (awvalid && r.awready) begin
      nx.aw_full  = 1'b1;
      nx.awaddr_q = awaddr;
    end
    if (wvalid && r.wready) begin
      nx.w_full  = 1'b1;
      nx.wbit_q  = wdata[sfifo_pkg::CTRL_DEPTH_BIT];
      nx.wlane_q = wstrb[0];
    end
    nx.awready = !nx.aw_full && !nx.bvalid;
    nx.wready  = !nx.w_full && !nx.bvalid;

    // read channel: answer on the same edge that takes the address
    if (r.rvalid && rready) nx.rvalid = 1'b0;
    if (arvalid && r.arready) begin
      nx.rvalid = 1'b1;
      nx.rdata  = rd_word;
      nx.rresp  = known_addr(araddr) ? sfifo_pkg::RESP_OKAY : sfifo_pkg::RESP_SLVERR;
    end
    nx.arready = !nx.rvalid;

    // per-part flags, last so a mode write lands with them; outside logic merges them across a chain
    nx.empty_n     = nx.fill != '0;
    nx.full_n      = nx.fill != FILL_FULL;
    nx.half_full_n = nx.depth_mode || (nx.fill <= FILL_HALF);
    nx.almost_n    = (nx.fill > FILL_LOW) && (nx.fill < FILL_HIGH);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= reset_state();
    end else if (ce) begin
      r <= nx;
    end
  end

  assign chain_token_out_n   = r.xo_n;
  assign empty_n             = r.empty_n;
  assign full_n              = r.full_n;
  assign half_full_n         = r.half_full_n;
  assign almost_empty_full_n = r.almost_n;
  assign data_out            = r.q;
  assign data_out_oe         = r.q_oe;
  assign awready             = r.awready;
  assign wready              = r.wready;
  assign bvalid              = r.bvalid;
  assign bresp               = r.bresp;
  assign arready             = r.arready;
  assign rvalid              = r.rvalid;
  assign rdata               = r.rdata;
  assign rresp               = r.rresp;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_ptrs: assert property (ce && !pin.reset_n |=> r.rptr == '0 && r.wptr == '0)
    else $error("reset left a pointer off zero");
  a_reset_flags: assert property (ce && !pin.reset_n |=> !empty_n && full_n && half_full_n
                                  && !almost_empty_full_n)
    else $error("reset flags wrong");
  a_rewind_ptr: assert property (ce && pin.reset_n && !pin.first_load_or_rewind_n_n && !r.depth_mode
                                 |=> r.rptr == '0 && r.wptr == PW'($past(r.wptr) + $past(wr_en)))
    else $error("rewind moved wrong pointer");
  a_write_step: assert property (ce && wr_en |=> r.wptr == PW'($past(r.wptr) + 1'b1)
                                 && mem[$past(r.wptr)] == $past(word))
    else $error("write pointer did not advance");
  a_no_read_empty: assert property (ce && !empty_n && pin.reset_n && pin.first_load_or_rewind_n_n |=> $stable(r.rptr))
    else $error("read pointer moved while empty");
  a_no_write_full: assert property (ce && !full_n && pin.reset_n |=> $stable(r.wptr))
    else $error("write pointer moved while full");
  a_chain_no_half: assert property (r.depth_mode |-> half_full_n)
    else $error("half-full flag active in chain mode");
  a_token_pulse: assert property (ce && (wr_wrap || rd_wrap) |=> (!chain_token_out_n)[*8])
    else $error("token output pulse too short");
  a_token_gate: assert property (ce && nw_rise && pin.reset_n && r.depth_mode
                                 && !(r.tok inside {sfifo_pkg::TOK_W, sfifo_pkg::TOK_WR}) |=> $stable(r.wptr))
    else $error("write without write token");
  a_token_reset: assert property (ce && !pin.reset_n |=> r.tok == ($past(pin.first_load_or_rewind_n_n)
                                  ? sfifo_pkg::TOK_NONE_W : sfifo_pkg::TOK_WR))
    else $error("token start state wrong after reset");
endmodule

// File: src/serial_word_shift.sv
// serial word assembler with data-set tap outputs
`timescale 1ns/1ps
module serial_word_shift #(
  parameter int WB = sfifo_pkg::WORD_BITS
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          step,
  input  wire logic          bit_in,
  input  wire logic          restart,
  output      logic [WB-1:0] word,
  output      logic          tap_low,
  output      logic          tap_high
);
  localparam int CW = $clog2(WB + 1);
  localparam logic [CW-1:0] CNT_WORD = CW'(WB);
  localparam logic [CW-1:0] CNT_LOW  = CW'(sfifo_pkg::TAP_LOW_BITS);
  localparam logic [CW-1:0] CNT_HIGH = CW'(sfifo_pkg::TAP_HIGH_BITS);

  typedef struct packed {
    logic [WB-1:0] word;
    logic [CW-1:0] count;
    logic          tap_low;
    logic          tap_high;
  } st_t;

  st_t           r;
  st_t           nx;
  logic          new_word;
  logic [CW-1:0] pos;

  // each accepted bit lands at its own index, first bit at zero
  always_comb begin
    nx       = r;
    new_word = (r.count == '0) || (r.count == CNT_WORD) || restart;
    pos      = new_word ? '0 : r.count;
    if (restart) begin
      nx.count = '0;
    end
    if (step) begin
      nx.word[pos] = bit_in;
      nx.count     = pos + 1'b1;
      nx.tap_low   = (pos + 1'b1) >= CNT_LOW;
      nx.tap_high  = (pos + 1'b1) >= CNT_HIGH;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= nx;
    end
  end

  assign word     = r.word;
  assign tap_low  = r.tap_low;
  assign tap_high = r.tap_high;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_taps_start_low: assert property (ce && step && new_word |=> !tap_low && !tap_high)
    else $error("taps not low at word start");
  a_tap_order: assert property (tap_high |-> tap_low)
    else $error("high tap rose before low tap");
  a_first_bit_lsb: assert property (ce && step && new_word |=> word[0] == $past(bit_in))
    else $error("first serial bit not at bit zero");
endmodule

// File: test/serial_fifo_reset_expansion_ctrl_tb.sv
// self-checking bench for the serial fifo control block
`timescale 1ns/1ps
module serial_fifo_reset_expansion_ctrl_tb;
  localparam int D = 8;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        serial_shift_clk, serial_data_in, serial_chain_in;
  logic        reset_n_in, first_load_or_rewind_n, chain_token_in_n, read_n;
  logic        tap_eight_bits, tap_nine_bits, chain_token_out_n, t9_prev;
  logic        empty_n, full_n, half_full_n, almost_empty_full_n, data_out_oe;
  logic [8:0]  data_out;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          bad_count = 0;
  int          comparisons = 0;
  int          xo_low = 0;

  serial_src serial_src_inst (.sclk(serial_shift_clk), .sdat(serial_data_in), .chain_en(serial_chain_in));

  // word loop closed through the nine-bit tap
  serial_fifo_reset_expansion_ctrl #(.DEPTH(D)) serial_fifo_reset_expansion_ctrl_inst (
    .aclk, .aresetn, .ce(1'b1), .serial_shift_clk, .serial_data_in, .serial_chain_in,
    .reset_n_in, .first_load_or_rewind_n, .chain_token_in_n, .next_word_n(tap_nine_bits),
    .read_n, .tap_eight_bits, .tap_nine_bits, .chain_token_out_n, .empty_n, .full_n,
    .half_full_n, .almost_empty_full_n, .data_out, .data_out_oe, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);

  always #2.5 aclk = ~aclk;

  // tap order and token pulse length watch
  always @(posedge aclk) begin
    if (tap_nine_bits === 1'b1 && t9_prev === 1'b0) check(tap_eight_bits, 1'b1);
    if (tap_nine_bits === 1'b0 && t9_prev === 1'b1) check(tap_eight_bits, 1'b0);
    if (chain_token_out_n === 1'b0) xo_low++;
    t9_prev = tap_nine_bits;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic hang;
    bad_count++;
    $display("BAD %0t wait ran out", $time);
    end_sim();
  endtask

  function automatic logic [8:0] wv(input int i);
    return 9'h1A5 ^ 9'(i * 83);
  endfunction

  // bus write: address and data offered together, each dropped when taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (++n > 50) hang();
    end while (!(bvalid && bready));
    bready <= 1'b0;
    check(bresp, sfifo_pkg::RESP_OKAY);
  endtask

  // bus read compared under a mask; the unaligned offset answers an error
  task automatic axr(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (++n > 50) hang();
    end while (!(rvalid && rready));
    rready <= 1'b0;
    check(rdata & m, e);
    check(rresp, (a == 4'h2) ? sfifo_pkg::RESP_SLVERR : sfifo_pkg::RESP_OKAY);
  endtask

  task automatic put(input int n);
    for (int i = 0; i < n; i++) serial_src_inst.send(wv(i));
  endtask

  task automatic pop;
    @(posedge aclk);
    read_n <= 1'b0;
    repeat (6) @(posedge aclk);
    check(data_out_oe, 1'b1);
    read_n <= 1'b1;
    repeat (6) @(posedge aclk);
    check(data_out_oe, 1'b0);
  endtask

  // low pulse of four cycles on one of the control pins
  task automatic pulse(input int which);
    @(posedge aclk);
    if (which == 0) reset_n_in <= 1'b0;
    else if (which == 1) first_load_or_rewind_n <= 1'b0;
    else chain_token_in_n <= 1'b0;
    repeat (4) @(posedge aclk);
    {reset_n_in, chain_token_in_n} <= 2'h3;
    if (which == 1) first_load_or_rewind_n <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask

  // main sequence
  initial begin
    {reset_n_in, first_load_or_rewind_n, chain_token_in_n, read_n, t9_prev} = 5'h1F;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    check({empty_n, full_n, half_full_n, almost_empty_full_n}, 4'h6);
    axr(4'h4, 32'h2F, 32'h26);
    axr(4'h2, 32'hFFFFFFFF, 32'h0);
    put(3);
    axr(4'h8, 32'hFFFF, 32'h3);
    axr(4'hC, 32'hFFFFFFFF, 32'h00030000);
    pop();
    check(data_out, wv(0));
    axr(4'hC, 32'hFFFFFFFF, 32'h00030001);
    pulse(1);
    axr(4'hC, 32'hFFFFFFFF, 32'h00030000);
    axr(4'h8, 32'hFFFF, 32'h3);
    repeat (3) pop();
    check(data_out, wv(2));
    pop();
    axr(4'hC, 32'hFFFFFFFF, 32'h00030003);
    check(empty_n, 1'b0);
    pulse(0);
    axr(4'hC, 32'hFFFFFFFF, 32'h0);
    put(D + 1);
    axr(4'h8, 32'hFFFF, D);
    check({full_n, half_full_n, almost_empty_full_n}, 3'h0);
    pop();
    check(data_out, wv(0));
    axw(4'h0, 32'h1);
    axr(4'h0, 32'hFFFFFFFF, 32'h1);
    first_load_or_rewind_n <= 1'b0; // first device of the chain
    pulse(0);
    axr(4'h4, 32'h1FF, {sfifo_pkg::TOK_WR, 6'h26});
    xo_low = 0;
    put(D);
    check(xo_low, sfifo_pkg::CHAIN_PULSE_CYC);
    check(half_full_n, 1'b1);
    pop();
    check(data_out, wv(0));
    first_load_or_rewind_n <= 1'b1; // later device of the chain
    pulse(0);
    axr(4'h4, 32'h1C3, {sfifo_pkg::TOK_NONE_W, 6'h02});
    put(1);
    axr(4'h8, 32'hFFFF, 32'h0);
    pulse(2);
    axr(4'h4, 32'h1C0, {sfifo_pkg::TOK_W, 6'h00});
    put(1);
    axr(4'h8, 32'hFFFF, 32'h1);
    end_sim();
  end
endmodule

// File: test/serial_src.sv
// serial source model that shifts words into the fifo
`timescale 1ns/1ps
module serial_src (
  output logic sclk,
  output logic sdat,
  output logic chain_en
);
  // idle link: clock parked low, chain input held high
  initial begin
    sclk     = 1'b0;
    sdat     = 1'b0;
    chain_en = 1'b1;
  end
  // one word lsb first on a 48 ns clock that runs only inside the frame
  task automatic send(input logic [8:0] w);
    for (int i = 0; i < 9; i++) begin
      sdat = w[i];
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
    sdat = ~w[8]; // released line shows the inverse
    #96;
  endtask
endmodule
